// ---- rtl/pcint_top.sv ----
// Purpose: Pin change interrupt block with an APB register slave.
// Assumes: Pins are asynchronous; the bus runs on clk_i.
// Notes: Zero wait state slave; read data is captured in setup.
//
// Decided for this implementation: the APB slave port and the register offsets.
`timescale 1ns/1ns
`include "pcint_cfg.svh"

module pcint_top
	import pcint_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic [`PCINT_A_W-1:0] first_gpio_bank_i,
	input wire logic [`PCINT_B_W-1:0] second_gpio_bank_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [`PCINT_ADDR_W-1:0] paddr_i,
	input wire logic [`PCINT_DATA_W-1:0] pwdata_i,
	output logic pready_o,
	output logic [`PCINT_DATA_W-1:0] prdata_o,
	output logic pslverr_o,
	output logic irq_o,
	output logic change_irq_summary_flag_o,
	output logic wake_o
);

	// ---------------------------------------------------------------
	// Helper functions.
	// ---------------------------------------------------------------

	// Decodes a byte address into a one-hot register select.
	function automatic pcint_sel_t pcint_decode
	(
		input logic [`PCINT_ADDR_W-1:0] addr
	);
		pcint_sel_t sel;
		sel = PCINT_SEL_NONE;
		case (addr)
			`PCINT_OFS_A_RISE: sel = PCINT_SEL_A_RISE;
			`PCINT_OFS_A_FALL: sel = PCINT_SEL_A_FALL;
			`PCINT_OFS_A_FLAG: sel = PCINT_SEL_A_FLAG;
			`PCINT_OFS_B_RISE: sel = PCINT_SEL_B_RISE;
			`PCINT_OFS_B_FALL: sel = PCINT_SEL_B_FALL;
			`PCINT_OFS_B_FLAG: sel = PCINT_SEL_B_FLAG;
			`PCINT_OFS_CTRL: sel = PCINT_SEL_CTRL;
			default: sel = PCINT_SEL_NONE;
		endcase
		return sel;
	endfunction

	// Places one bank of a pin vector into its register word.
	function automatic logic [`PCINT_DATA_W-1:0] pcint_to_word
	(
		input logic [`PCINT_PINS-1:0] v,
		input logic bank_b
	);
		logic [`PCINT_DATA_W-1:0] w;
		w = `PCINT_RST_WORD;
		if (bank_b)
		begin
			w[`PCINT_B_LSB +: `PCINT_B_W] = v[`PCINT_A_W +: `PCINT_B_W];
		end
		else
		begin
			w[`PCINT_A_W-1:0] = v[`PCINT_A_W-1:0];
		end
		return w;
	endfunction

	// Replaces one bank of a pin vector with bits from a bus word.
	function automatic logic [`PCINT_PINS-1:0] pcint_from_word
	(
		input logic [`PCINT_PINS-1:0] old,
		input logic [`PCINT_DATA_W-1:0] w,
		input logic bank_b
	);
		logic [`PCINT_PINS-1:0] v;
		v = old;
		if (bank_b)
		begin
			v[`PCINT_A_W +: `PCINT_B_W] = w[`PCINT_B_LSB +: `PCINT_B_W];
		end
		else
		begin
			v[`PCINT_A_W-1:0] = w[`PCINT_A_W-1:0];
		end
		return v;
	endfunction

	// ---------------------------------------------------------------
	// Declarations.
	// ---------------------------------------------------------------
	logic [`PCINT_PINS-1:0] pin_w; // Both banks, second bank on top.
	logic [`PCINT_PINS-1:0] sync1_r; // First synchroniser stage.
	logic [`PCINT_PINS-1:0] sync2_r; // Second synchroniser stage.
	logic [`PCINT_PINS-1:0] sync3_r; // Third synchroniser stage.
	logic [`PCINT_PINS-1:0] stable_r; // Last accepted pin level.
	logic [`PCINT_PINS-1:0] stable_nxt; // Accepted level this cycle.
	logic [`PCINT_PINS-1:0] rise_ev_w; // Accepted rising transitions.
	logic [`PCINT_PINS-1:0] fall_ev_w; // Accepted falling transitions.
	logic [`PCINT_PINS-1:0] ev_w; // Any accepted transition.
	logic [`PCINT_PINS-1:0] det_w; // Enabled edges this cycle.
	pcint_edge_cfg_t cfg_r; // Edge enable registers.
	logic [`PCINT_PINS-1:0] flags_r; // Sticky change flags.
	logic [`PCINT_PINS-1:0] flags_nxt; // Next flag value.
	logic [`PCINT_PINS-1:0] hold_r; // Edges seen in a clear's setup.
	logic master_en_r; // Master change interrupt enable.
	logic any_flag_w; // OR of all pin flags.
	pcint_sel_t sel_w; // Decoded register select.
	logic setup_w; // APB setup cycle.
	logic access_w; // APB access cycle.
	logic wr_w; // Write taking effect this edge.
	logic flag_setup_w; // Setup cycle of a write to a flag register.
	logic [`PCINT_DATA_W-1:0] rd_nxt; // Read word for the next access.
	logic [`PCINT_DATA_W-1:0] prdata_r; // Registered read data.

	// ---------------------------------------------------------------
	// Pin synchroniser and edge detection.
	// ---------------------------------------------------------------

	// Gathers both banks into one vector.
	assign pin_w = {second_gpio_bank_i, first_gpio_bank_i};

	// Three flops per pin; the first is read only by the second.
	always_ff @(posedge clk_i)
	begin
		if (!rst_b_i)
		begin
			sync1_r <= `PCINT_RST_PINS;
			sync2_r <= `PCINT_RST_PINS;
			sync3_r <= `PCINT_RST_PINS;
		end
		else
		begin
			sync1_r <= pin_w;
			sync2_r <= sync1_r;
			sync3_r <= sync2_r;
		end
	end

	// A new level is accepted only once stages two and three agree.
	always_comb
	begin
		stable_nxt = (~(sync2_r ^ sync3_r) & sync3_r) |
			((sync2_r ^ sync3_r) & stable_r);
		rise_ev_w = stable_nxt & ~stable_r;
		fall_ev_w = ~stable_nxt & stable_r;
		ev_w = rise_ev_w | fall_ev_w;
		// Each pin is gated by its own enables, either or both.
		det_w = (rise_ev_w & cfg_r.rise) | (fall_ev_w & cfg_r.fall);
	end

	// Keeps the accepted level so each transition is seen once.
	always_ff @(posedge clk_i)
	begin
		if (!rst_b_i)
		begin
			stable_r <= `PCINT_RST_PINS;
		end
		else
		begin
			stable_r <= stable_nxt;
		end
	end

	// ---------------------------------------------------------------
	// APB decode.
	// ---------------------------------------------------------------

	// Splits the bus transfer into its phases.
	always_comb
	begin
		sel_w = pcint_decode(paddr_i);
		setup_w = psel_i & ~penable_i;
		access_w = psel_i & penable_i;
		wr_w = access_w & pwrite_i;
		flag_setup_w = setup_w & pwrite_i &
			((sel_w == PCINT_SEL_A_FLAG) || (sel_w == PCINT_SEL_B_FLAG));
	end

	// The slave never stalls; unmapped addresses answer with an error.
	assign pready_o = 1'b1;
	assign pslverr_o = access_w & (sel_w == PCINT_SEL_NONE);

	// ---------------------------------------------------------------
	// Configuration registers.
	// ---------------------------------------------------------------

	// Edge enables for both banks, written a bank at a time.
	always_ff @(posedge clk_i)
	begin
		if (!rst_b_i)
		begin
			cfg_r.rise <= `PCINT_RST_PINS;
			cfg_r.fall <= `PCINT_RST_PINS;
		end
		else if (wr_w)
		begin
			unique case (sel_w)
				PCINT_SEL_A_RISE: cfg_r.rise <= pcint_from_word(cfg_r.rise,
					pwdata_i, 1'b0);
				PCINT_SEL_B_RISE: cfg_r.rise <= pcint_from_word(cfg_r.rise,
					pwdata_i, 1'b1);
				PCINT_SEL_A_FALL: cfg_r.fall <= pcint_from_word(cfg_r.fall,
					pwdata_i, 1'b0);
				PCINT_SEL_B_FALL: cfg_r.fall <= pcint_from_word(cfg_r.fall,
					pwdata_i, 1'b1);
				default:
				begin
					cfg_r <= cfg_r;
				end
			endcase
		end
	end

	// Master enable in the interrupt control register.
	always_ff @(posedge clk_i)
	begin
		if (!rst_b_i)
		begin
			master_en_r <= 1'b0;
		end
		else if (wr_w && (sel_w == PCINT_SEL_CTRL))
		begin
			master_en_r <= pwdata_i[`PCINT_MASTER_BIT];
		end
	end

	// ---------------------------------------------------------------
	// Change flags.
	// ---------------------------------------------------------------

	// Remembers edges caught while a clearing write sits in setup.
	always_ff @(posedge clk_i)
	begin
		if (!rst_b_i)
		begin
			hold_r <= `PCINT_RST_PINS;
		end
		else if (flag_setup_w)
		begin
			hold_r <= det_w;
		end
		else
		begin
			hold_r <= `PCINT_RST_PINS;
		end
	end

	// Hardware sets win over a clear; writing one leaves a flag alone.
	always_comb
	begin
		flags_nxt = flags_r;
		if (wr_w && (sel_w == PCINT_SEL_A_FLAG))
		begin
			flags_nxt = pcint_from_word(flags_r,
				pcint_to_word(flags_r, 1'b0) & pwdata_i, 1'b0);
			flags_nxt = flags_nxt | hold_r;
		end
		else if (wr_w && (sel_w == PCINT_SEL_B_FLAG))
		begin
			flags_nxt = pcint_from_word(flags_r,
				pcint_to_word(flags_r, 1'b1) & pwdata_i, 1'b1);
			flags_nxt = flags_nxt | hold_r;
		end
		flags_nxt = flags_nxt | det_w;
	end

	// Flag storage.
	always_ff @(posedge clk_i)
	begin
		if (!rst_b_i)
		begin
			flags_r <= `PCINT_RST_PINS;
		end
		else
		begin
			flags_r <= flags_nxt;
		end
	end

	// ---------------------------------------------------------------
	// Summary, interrupt and wake.
	// ---------------------------------------------------------------

	// The summary flag and requests follow the flag flops directly.
	assign any_flag_w = |flags_r;
	assign change_irq_summary_flag_o = any_flag_w;
	assign irq_o = master_en_r & any_flag_w;
	// Flags are already set when the wake request rises.
	assign wake_o = master_en_r & any_flag_w;

	// ---------------------------------------------------------------
	// Read data.
	// ---------------------------------------------------------------

	// Selects the word for a read; unmapped addresses read zero.
	always_comb
	begin
		rd_nxt = `PCINT_RST_WORD;
		unique case (sel_w)
			PCINT_SEL_A_RISE: rd_nxt = pcint_to_word(cfg_r.rise, 1'b0);
			PCINT_SEL_A_FALL: rd_nxt = pcint_to_word(cfg_r.fall, 1'b0);
			PCINT_SEL_A_FLAG: rd_nxt = pcint_to_word(flags_r, 1'b0);
			PCINT_SEL_B_RISE: rd_nxt = pcint_to_word(cfg_r.rise, 1'b1);
			PCINT_SEL_B_FALL: rd_nxt = pcint_to_word(cfg_r.fall, 1'b1);
			PCINT_SEL_B_FLAG: rd_nxt = pcint_to_word(flags_r, 1'b1);
			PCINT_SEL_CTRL:
			begin
				rd_nxt[`PCINT_MASTER_BIT] = master_en_r;
				rd_nxt[`PCINT_SUMMARY_BIT] = any_flag_w;
			end
			PCINT_SEL_NONE: rd_nxt = `PCINT_RST_WORD;
			default: rd_nxt = `PCINT_RST_WORD;
		endcase
	end

	// Captures read data in the setup cycle for the access cycle.
	always_ff @(posedge clk_i)
	begin
		if (!rst_b_i)
		begin
			prdata_r <= `PCINT_RST_WORD;
		end
		else if (setup_w && !pwrite_i)
		begin
			prdata_r <= rd_nxt;
		end
	end

	assign prdata_o = prdata_r;

	// ---------------------------------------------------------------
	// Assertions.
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);

	a_irq_needs_master: assert property (
		irq_o |-> master_en_r)
		else $error("Interrupt raised with master enable clear.");

	a_irq_on_edge: assert property (
		(det_w != 10'h000) && master_en_r |=> irq_o && wake_o)
		else $error("Enabled edge did not raise interrupt and wake.");

	a_edge_sets_flag: assert property (
		(det_w != 10'h000) |=> ((flags_r & $past(det_w)) == $past(det_w)))
		else $error("Enabled edge did not set its flag.");

	a_flag_has_cause: assert property (
		((flags_r & ~$past(flags_r)) & ~$past(det_w)) == 10'h000)
		else $error("Flag set without an enabled edge.");

	a_clear_takes: assert property (
		wr_w && (sel_w == PCINT_SEL_A_FLAG) &&
		(pwdata_i[5:0] == 6'h00) && (det_w == 10'h000) &&
		(hold_r == 10'h000) |=> flags_r[5:0] == 6'h00)
		else $error("Writing zero did not clear first bank flags.");

	a_edge_beats_clear: assert property (
		flag_setup_w && (det_w != 10'h000) ##1 wr_w
		|=> ((flags_r & $past(hold_r)) == $past(hold_r)))
		else $error("Edge during a clearing write was lost.");

	a_single_event: assert property (
		(ev_w != 10'h000) |=> ((ev_w & $past(ev_w)) == 10'h000))
		else $error("One transition reported twice.");

	a_reset_clear: assert property (
		$rose(rst_b_i) |-> (flags_r == 10'h000) &&
		(cfg_r == '0) && !master_en_r)
		else $error("Enables or flags not zero after reset.");

	a_summary_read: assert property (
		setup_w && !pwrite_i && (sel_w == PCINT_SEL_CTRL)
		|=> prdata_o[0] == $past(any_flag_w))
		else $error("Summary flag read does not match pin flags.");

	a_first_unimpl: assert property (
		access_w && !pwrite_i && $past(setup_w) &&
		(sel_w == PCINT_SEL_A_FLAG) |-> prdata_o[31:6] == 26'h0)
		else $error("First bank upper bits not zero.");

	a_second_unimpl: assert property (
		access_w && !pwrite_i && $past(setup_w) &&
		(sel_w == PCINT_SEL_B_FLAG)
		|-> (prdata_o[3:0] == 4'h0) && (prdata_o[31:8] == 24'h0))
		else $error("Second bank unused bits not zero.");

	c_both_edges: cover property (
		(rise_ev_w & cfg_r.rise & cfg_r.fall) != 10'h000 ##[1:50]
		(fall_ev_w & cfg_r.rise & cfg_r.fall) != 10'h000);

	c_edge_in_clear: cover property (
		flag_setup_w && (det_w != 10'h000) ##1 wr_w);

	c_irq_raised: cover property (!irq_o ##1 irq_o);

endmodule

// ---- rtl/pcint_cfg.svh ----
// Purpose: Constants for the pin change interrupt block.
// Assumes: APB slave with 32-bit data and byte addresses.
// Notes: Offsets, field positions, reset values and widths live here.
//
// How it works
// - Detect changes on first bank and second bank.
// - Every pin configured on its own.
// - Interrupt only while master enable is set.
// - Per-pin rising detector gated by rise enable.
// - Per-pin falling detector gated by fall enable.
// - Both enables set flags either direction.
// - Enabled edge sets flag and requests interrupt.
// - Summary flag is OR of all pin flags.
// - Writing zero to a flag clears it.
// - Edge during clearing write keeps flag set.
// - Enabled change wakes device while master enable is set, flags already updated.
// - First bank uses bits 5 to 0.
// - Second bank uses bits 7 to 4.
`ifndef PCINT_CFG_SVH
`define PCINT_CFG_SVH

// ---------------------------------------------------------------
// Register offsets (byte addresses).
// ---------------------------------------------------------------
`define PCINT_OFS_A_RISE 8'h00
`define PCINT_OFS_A_FALL 8'h04
`define PCINT_OFS_A_FLAG 8'h08
`define PCINT_OFS_B_RISE 8'h0C
`define PCINT_OFS_B_FALL 8'h10
`define PCINT_OFS_B_FLAG 8'h14
`define PCINT_OFS_CTRL 8'h18

// ---------------------------------------------------------------
// Field layout and widths.
// ---------------------------------------------------------------
`define PCINT_ADDR_W 8
`define PCINT_DATA_W 32
`define PCINT_A_W 6
`define PCINT_B_W 4
`define PCINT_B_LSB 4
`define PCINT_PINS 10
`define PCINT_MASTER_BIT 3
`define PCINT_SUMMARY_BIT 0

// ---------------------------------------------------------------
// Reset values.
// ---------------------------------------------------------------
`define PCINT_RST_PINS 10'h000
`define PCINT_RST_WORD 32'h0000_0000

`endif

// ---- rtl/pcint_pkg.sv ----
// Purpose: Types shared by the pin change interrupt block.
// Assumes: The constants header is available on the include path.
// Notes: Holds types only; pin widths come from the header, the select codes are set here.
`include "pcint_cfg.svh"

package pcint_pkg;

	// Per-pin edge enables, second bank above first bank.
	typedef struct packed
	{
		logic [`PCINT_PINS-1:0] rise;
		logic [`PCINT_PINS-1:0] fall;
	} pcint_edge_cfg_t;

	// One-hot register select from the address decoder.
	typedef enum logic [7:0]
	{
		PCINT_SEL_NONE = 8'h01,
		PCINT_SEL_A_RISE = 8'h02,
		PCINT_SEL_A_FALL = 8'h04,
		PCINT_SEL_A_FLAG = 8'h08,
		PCINT_SEL_B_RISE = 8'h10,
		PCINT_SEL_B_FALL = 8'h20,
		PCINT_SEL_B_FLAG = 8'h40,
		PCINT_SEL_CTRL = 8'h80
	} pcint_sel_t;

endpackage

// ---- tb/pcint_pin_model.sv ----
// Purpose: Model of the pins and the core interrupt input around the block.
// Assumes: The bench asks for pin levels right after a clock edge.
// Notes: Pins are always driven; the core side counts new requests.
`timescale 1ns/1ns
`include "pcint_cfg.svh"

module pcint_pin_model
(
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic [`PCINT_PINS-1:0] pin_req_i,
	input wire logic irq_i,
	output logic [`PCINT_A_W-1:0] first_gpio_bank_o,
	output logic [`PCINT_B_W-1:0] second_gpio_bank_o,
	output logic [7:0] irq_rises_o
);
	// Interrupt level seen at the previous edge.
	logic irq_last_r;

	// Pins follow the levels asked for; second bank sits above the first.
	assign first_gpio_bank_o = pin_req_i[`PCINT_A_W-1:0];
	assign second_gpio_bank_o = pin_req_i[`PCINT_PINS-1:`PCINT_A_W];

	// The core takes each new interrupt request once, on its rising level.
	always_ff @(posedge clk_i)
	begin
		if (!rst_b_i)
		begin
			irq_last_r <= 1'b0;
			irq_rises_o <= 8'h00;
		end
		else
		begin
			irq_last_r <= irq_i;
			if (irq_i && !irq_last_r)
				irq_rises_o <= irq_rises_o + 8'h01;
		end
	end
endmodule

// ---- tb/pin_change_interrupt_tb.sv ----
// Purpose: Self-checking bench for the pin change interrupt block.
// Assumes: Zero wait APB slave; pins pass three sync flops.
// Notes: Table rows cover the register map; edge cases follow by hand.
`timescale 1ns/1ns
`include "pcint_cfg.svh"

module pin_change_interrupt_tb;
	import pcint_pkg::*;

	// One register row: address, and the value read back after all ones.
	typedef struct packed
	{
		logic [7:0] addr;
		logic [31:0] exp;
	} pcint_row_t;

	logic clk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [`PCINT_PINS-1:0] pin_req = 10'h000;
	logic [5:0] bank_a;
	logic [3:0] bank_b;
	logic pready_o, pslverr_o, irq_o, summ_o, wake_o;
	logic [31:0] prdata_o, rdata;
	logic rerr;
	logic [7:0] irq_rises;
	int num_errors = 0;
	int comparisons = 0;
	pcint_row_t rows [8];

	// 100 MHz clock.
	always #5 clk_i = ~clk_i;

	pcint_top uut (.clk_i(clk_i), .rst_b_i(rst_b_i),
		.first_gpio_bank_i(bank_a), .second_gpio_bank_i(bank_b),
		.psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
		.paddr_i(paddr), .pwdata_i(pwdata), .pready_o(pready_o),
		.prdata_o(prdata_o), .pslverr_o(pslverr_o), .irq_o(irq_o),
		.change_irq_summary_flag_o(summ_o), .wake_o(wake_o));

	pcint_pin_model partner (.clk_i(clk_i), .rst_b_i(rst_b_i),
		.pin_req_i(pin_req), .irq_i(irq_o), .first_gpio_bank_o(bank_a),
		.second_gpio_bank_o(bank_b), .irq_rises_o(irq_rises));

	// Compares one value and counts it.
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("Error at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask

	// One APB transfer; read data and error are taken at the pready edge.
	task automatic xfer(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk_i);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_i);
		penable <= 1'b1;
		@(posedge clk_i);
		while (pready_o !== 1'b1)
			@(posedge clk_i);
		rdata = prdata_o;
		rerr = pslverr_o;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Reads a register and compares it.
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 32'h0000_0000);
		check(rdata, exp);
	endtask

	// Sets the pins and lets the synchronised edge reach the flags.
	task automatic pins(input logic [`PCINT_PINS-1:0] v);
		@(posedge clk_i);
		pin_req <= v;
		repeat (6) @(posedge clk_i);
	endtask

	// Interrupt, summary and wake outputs as one word.
	function automatic logic [31:0] outs();
		return {29'h0, irq_o, summ_o, wake_o};
	endfunction

	// Prints the counts and the verdict, then stops.
	task automatic conclude();
		$display("Comparisons %0d, errors %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// Cuts a hang short.
	initial
	begin
		repeat (20000) @(posedge clk_i);
		num_errors++;
		conclude();
	end

	// -----------------------------------------------------------------
	// Main sequence.
	// -----------------------------------------------------------------
	initial
	begin
		rows[0] = '{`PCINT_OFS_A_RISE, 32'h0000_003F};
		rows[1] = '{`PCINT_OFS_A_FALL, 32'h0000_003F};
		rows[2] = '{`PCINT_OFS_A_FLAG, 32'h0000_0000};
		rows[3] = '{`PCINT_OFS_B_RISE, 32'h0000_00F0};
		rows[4] = '{`PCINT_OFS_B_FALL, 32'h0000_00F0};
		rows[5] = '{`PCINT_OFS_B_FLAG, 32'h0000_0000};
		rows[6] = '{`PCINT_OFS_CTRL, 32'h0000_0008};
		rows[7] = '{8'h1C, 32'h0000_0000};
		repeat (3) @(posedge clk_i);
		rst_b_i <= 1'b1;
		// All ones written: unused bits, summary and flag ones are dropped.
		foreach (rows[i])
		begin
			rd(rows[i].addr, 32'h0000_0000);
			xfer(1'b1, rows[i].addr, 32'hFFFF_FFFF);
			rd(rows[i].addr, rows[i].exp);
			check({31'h0, rerr}, {31'h0, rows[i].addr == 8'h1C});
		end
		// Both edges enabled on a first bank pin.
		pins(10'h001);
		rd(`PCINT_OFS_A_FLAG, 32'h0000_0001);
		check(outs(), 32'h0000_0007);
		check({24'h0, irq_rises}, 32'h0000_0001);
		// Clear with an AND mask of the bits known to be set.
		// Ones in the mask leave unknown flags alone; zeros clear known ones.
		xfer(1'b1, `PCINT_OFS_A_FLAG, ~rdata);
		rd(`PCINT_OFS_A_FLAG, 32'h0000_0000);
		check(outs(), 32'h0000_0000);
		pins(10'h000);
		rd(`PCINT_OFS_A_FLAG, 32'h0000_0001);
		xfer(1'b1, `PCINT_OFS_A_FLAG, 32'h0000_0000);
		// Second bank pin 3 lands on flag bit 7.
		pins(10'h200);
		rd(`PCINT_OFS_B_FLAG, 32'h0000_0080);
		rd(`PCINT_OFS_A_FLAG, 32'h0000_0000);
		check(outs(), 32'h0000_0007);
		xfer(1'b1, `PCINT_OFS_B_FLAG, 32'h0000_0000);
		// Rise only on pin 1; pin 2 not enabled at all.
		xfer(1'b1, `PCINT_OFS_A_FALL, 32'h0000_0000);
		xfer(1'b1, `PCINT_OFS_A_RISE, 32'h0000_0002);
		pins(10'h206);
		rd(`PCINT_OFS_A_FLAG, 32'h0000_0002);
		xfer(1'b1, `PCINT_OFS_A_FLAG, 32'h0000_0000);
		pins(10'h200);
		rd(`PCINT_OFS_A_FLAG, 32'h0000_0000);
		// Master off: flag still sets, no interrupt until master returns.
		xfer(1'b1, `PCINT_OFS_CTRL, 32'h0000_0000);
		pins(10'h202);
		rd(`PCINT_OFS_A_FLAG, 32'h0000_0002);
		check(outs(), 32'h0000_0002);
		rd(`PCINT_OFS_CTRL, 32'h0000_0001);
		xfer(1'b1, `PCINT_OFS_CTRL, 32'h0000_0008);
		// The enable lands at the access edge; look one edge later.
		@(posedge clk_i);
		check(outs(), 32'h0000_0007);
		xfer(1'b1, `PCINT_OFS_A_FLAG, 32'h0000_0000);
		// Edge detected inside a clearing write keeps its flag.
		xfer(1'b1, `PCINT_OFS_A_RISE, 32'h0000_0028);
		pins(10'h20A);
		@(posedge clk_i);
		pin_req <= 10'h22A;
		@(posedge clk_i);
		xfer(1'b1, `PCINT_OFS_A_FLAG, 32'h0000_0000);
		repeat (6) @(posedge clk_i);
		rd(`PCINT_OFS_A_FLAG, 32'h0000_0020);
		// Same again with the falling edge landing in the setup cycle.
		xfer(1'b1, `PCINT_OFS_A_FALL, 32'h0000_0020);
		@(posedge clk_i);
		pin_req <= 10'h20A;
		repeat (2) @(posedge clk_i);
		xfer(1'b1, `PCINT_OFS_A_FLAG, 32'h0000_0000);
		repeat (6) @(posedge clk_i);
		rd(`PCINT_OFS_A_FLAG, 32'h0000_0020);
		// Reset in mid-run clears flags, enables and outputs.
		@(posedge clk_i);
		rst_b_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		rst_b_i <= 1'b1;
		rd(`PCINT_OFS_A_FLAG, 32'h0000_0000);
		rd(`PCINT_OFS_A_RISE, 32'h0000_0000);
		check(outs(), 32'h0000_0000);
		check({31'h0, pready_o}, 32'h0000_0001);
		conclude();
	end
endmodule
